// ### design/bcbn_pkg.sv
package bcbn_pkg;
  // ****************************************************************
  // Instruction encodings
  // ****************************************************************
  localparam logic [3:0] BCLR_PREFIX = 4'h9;
  localparam logic [7:0] BNEG_OPCODE = 8'he6;
  localparam int BCLR_PREFIX_HI = 15;
  localparam int BCLR_PREFIX_LO = 12;
  localparam int BIT_IDX_HI = 11;
  localparam int BIT_IDX_LO = 9;
  localparam int BANK_MODE_BIT = 8;
  localparam int FILE_HI = 7;
  localparam int OPC_HI = 15;
  localparam int OPC_LO = 8;

  // ****************************************************************
  // Addressing and phase constants
  // ****************************************************************
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q3 = 2'h2;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  typedef enum logic [1:0] {
    BCBN_EXEC,
    BCBN_FLUSH
  } bcbn_state_t;
endpackage

// ### design/bcbn_mem_if.sv
// Data memory access bundle between the core and its file register store
interface bcbn_mem_if;
  import bcbn_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [7:0] rdata;
  logic [7:0] wdata;
  logic we;
  modport core (output addr, output wdata, output we, input rdata);
  modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ### design/bcbn_filemem.sv
// ****************************************************************
// File register store, registered read
// ****************************************************************
module bcbn_filemem (
  input wire logic clk,
  bcbn_mem_if.mem port
);
  import bcbn_pkg::*;

  logic [7:0] mem_r [0:(1<<ADDR_W)-1];
  logic [7:0] rdata_r;

  // Write port; no reset so the array maps onto plain RAM
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_r[port.addr] <= port.wdata;
    end
  end

  // Registered read, one cycle after the address is presented
  always_ff @(posedge clk) begin
    rdata_r <= mem_r[port.addr];
  end

  assign port.rdata = rdata_r;
endmodule

// ### design/bcbn_core.sv
// Operation
// - Bank-mode zero takes address from the fixed access bank.
// - Bank-mode one uses the bank selector to choose the bank.
// - Bank-mode zero, extended set, address up to 5Fh: indexed literal offset.
// - Branch on negative jumps only when negative flag is one.
// - Taken branch adds the doubled sign-extended offset to PC.
// - Target equals branch address plus 2 plus doubled offset.
// - Taken branch takes two cycles, second a no-op; others one.
module bcbn_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [3:0] bank_selector,
  input wire logic [11:0] index_base,
  input wire logic extended_en,
  input wire logic negative_flag,
  output logic [bcbn_pkg::PC_W-1:0] pc,
  output logic [1:0] phase,
  output logic busy,
  output logic instr_done,
  output logic branch_taken,
  output logic illegal,
  output logic [bcbn_pkg::ADDR_W-1:0] file_addr
);
  import bcbn_pkg::*;

  // ****************************************************************
  // Memory and decode
  // ****************************************************************
  // The store has no reset: clearing an unwritten byte leaves its other bits unknown
  bcbn_mem_if mem ();

  bcbn_filemem u_mem (
    .clk(clk),
    .port(mem)
  );

  // Sequencing state
  logic [15:0] ir_r;
  logic [15:0] ir_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [1:0] phase_r;
  bcbn_state_t state_r;
  bcbn_state_t state_nxt;

  // Decoded fields
  logic is_bclr;
  logic is_bneg;
  logic bank_mode;
  logic [7:0] faddr;
  logic [2:0] bit_idx;

  // Operand address and branch target
  logic [ADDR_W-1:0] eff_addr;
  logic [PC_W-1:0] offset_ext;
  logic take;

  // Registered outputs
  logic done_r;
  logic taken_r;
  logic illegal_r;
  logic [ADDR_W-1:0] addr_r;

  // Field extraction from the latched word
  assign is_bclr = (ir_r[BCLR_PREFIX_HI:BCLR_PREFIX_LO] == BCLR_PREFIX);
  assign is_bneg = (ir_r[OPC_HI:OPC_LO] == BNEG_OPCODE);
  assign bit_idx = ir_r[BIT_IDX_HI:BIT_IDX_LO];
  assign bank_mode = ir_r[BANK_MODE_BIT];
  assign faddr = ir_r[FILE_HI:0];

  // ****************************************************************
  // Operand address resolution
  // ****************************************************************
  // Indexed mode wins over plain access bank when the extension is on
  // Access bank: offsets below the split from bank 0, the rest from the top bank
  always_comb begin
    if (!bank_mode && extended_en && faddr <= INDEXED_LIMIT) begin
      eff_addr = index_base + {4'h0, faddr};
    end else if (!bank_mode) begin
      eff_addr = (faddr < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, faddr} : {ACCESS_HIGH_BANK, faddr};
    end else begin
      eff_addr = {bank_selector, faddr};
    end
  end

  // Read in Q2 (data back by Q3), modify and write in Q4
  assign mem.addr = eff_addr;
  assign mem.wdata = mem.rdata & ~(8'h01 << bit_idx);
  assign mem.we = (state_r == BCBN_EXEC) && (phase_r == PHASE_Q4) && is_bclr;

  // ****************************************************************
  // Branch target
  // ****************************************************************
  // Flag sampled at end of cycle; status is never written here
  // Offset counts words, so the doubling keeps every target on an even address
  assign offset_ext = {{(PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};
  assign take = is_bneg && negative_flag;

  // Phase counter: four core clocks make one instruction cycle
  // It free-runs through a flush; only the latch, the jump, the write and the status pulses are gated by state
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_r <= PHASE_Q1;
    end else begin
      phase_r <= phase_r + 2'h1;
    end
  end

  // Next-state: a taken branch inserts one flush cycle
  // Words are taken only at Q1 outside a flush, so a jump never runs the old successor
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    if (phase_r == PHASE_Q4) begin
      unique case (state_r)
        BCBN_EXEC: begin
          if (take) begin
            pc_nxt = pc_r + offset_ext;
            state_nxt = BCBN_FLUSH;
          end else begin
            pc_nxt = pc_r;
          end
        end
        BCBN_FLUSH: begin
          state_nxt = BCBN_EXEC;
        end
        default: begin
          state_nxt = BCBN_EXEC;
        end
      endcase
    end else if (phase_r == PHASE_Q1 && state_r == BCBN_EXEC && instr_valid) begin
      ir_nxt = instr;
      pc_nxt = pc_r + PC_STEP;  // PC already past the word during execution
    end
  end

  // ****************************************************************
  // Sequencing registers
  // ****************************************************************
  // State only moves on a Q4 edge, so a flush spans one whole instruction cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= BCBN_EXEC;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Program counter; steps on a Q1 latch, jumps on a taken Q4
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_r <= PC_RESET;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // Instruction register; the reset word decodes as neither instruction
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_r <= 16'h0000;
    end else begin
      ir_r <= ir_nxt;
    end
  end

  // ****************************************************************
  // Status pulses
  // ****************************************************************
  // Completion one clock after the final Q4; a taken branch waits for its flush
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (phase_r == PHASE_Q4) && (state_r == BCBN_FLUSH || !take);
    end
  end

  // Taken pulse lines up with the PC write, not with completion
  always_ff @(posedge clk) begin
    if (reset) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= (phase_r == PHASE_Q4) && (state_r == BCBN_EXEC) && take;
    end
  end

  // Unknown words still retire in one cycle but change nothing
  always_ff @(posedge clk) begin
    if (reset) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= (phase_r == PHASE_Q4) && (state_r == BCBN_EXEC) && !is_bclr && !is_bneg;
    end
  end

  // Last cleared address, held until the next clear
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_r <= 12'h000;
    end else if (mem.we) begin
      addr_r <= eff_addr;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Registered values straight out; busy is decoded from the state register
  assign pc = pc_r;
  assign phase = phase_r;
  assign busy = (state_r == BCBN_FLUSH);
  assign instr_done = done_r;
  assign branch_taken = taken_r;
  assign illegal = illegal_r;
  assign file_addr = addr_r;
endmodule

// ### bench/bcbn_core_properties.sv
// ***
// Port checker
// ***
module bcbn_core_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] instr,
  input wire logic [3:0] bank_selector,
  input wire logic [11:0] index_base,
  input wire logic extended_en,
  input wire logic negative_flag,
  input wire logic [bcbn_pkg::PC_W-1:0] pc,
  input wire logic [1:0] phase,
  input wire logic busy,
  input wire logic instr_done,
  input wire logic branch_taken,
  input wire logic illegal,
  input wire logic [bcbn_pkg::ADDR_W-1:0] file_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import bcbn_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Latch of each kind; operands are read back 4 edges later
  sequence s_bc; phase == PHASE_Q1 && !busy && instr[15:12] == BCLR_PREFIX; endsequence
  sequence s_bn; phase == PHASE_Q1 && !busy && instr[15:8] == BNEG_OPCODE; endsequence
  sequence s_jump; s_bn ##3 negative_flag; endsequence
  a_pc_step:
    assert property (phase == PHASE_Q1 && !busy |=> pc == $past(pc) + PC_STEP) else $error("pc step");
  a_clear_time:
    assert property (s_bc |-> ##4 instr_done) else $error("clear time");
  a_skip_time:
    assert property (s_bn ##3 !negative_flag |-> ##1 !busy && instr_done && !branch_taken) else $error("skip time");
  a_jump_flush:
    assert property (s_jump |-> ##1 (busy && !instr_done) [*4] ##1 !busy && instr_done) else $error("flush");
  a_jump_target:
    assert property (s_jump |-> ##1 pc == $past(pc) + {{12{$past(instr[7], 4)}}, $past(instr[7:0], 4), 1'b0})
      else $error("target");
  a_bank_sel:
    assert property (s_bc ##0 instr[8] |-> ##4 file_addr == {$past(bank_selector), $past(instr[7:0], 4)})
      else $error("bank");
  a_access_bank:
    assert property (s_bc ##0 !instr[8] ##3 !extended_en |-> ##1 file_addr ==
      {(($past(instr[7:0], 4) < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK), $past(instr[7:0], 4)})
      else $error("access");
  a_indexed_mode:
    assert property (s_bc ##0 !instr[8] && instr[7:0] <= INDEXED_LIMIT ##3 extended_en |->
      ##1 file_addr == $past(index_base) + {4'h0, $past(instr[7:0], 4)}) else $error("indexed");
  a_jump_flag:
    assert property (s_jump |-> ##1 branch_taken) else $error("taken flag");
  a_clear_legal:
    assert property (s_bc |-> ##4 !illegal && !branch_taken) else $error("clear legal");
  a_flag_bad:
    assert property (phase == PHASE_Q1 && !busy && instr[15:12] != BCLR_PREFIX && instr[15:8] != BNEG_OPCODE |->
      ##4 illegal && instr_done) else $error("illegal flag");
endmodule

// ### bench/bcbn_fetch_model.sv
// ***
// Program store
// ***
module bcbn_fetch_model (
  input wire logic [7:0] word_sel,
  output logic [15:0] instr,
  output logic instr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] rom [256];
  // Small store, so far branches alias; the bench writes each word before its fetch
  assign instr = rom[word_sel];
  assign instr_valid = 1'b1;
endmodule

// ### bench/bit_clear_and_negative_branch_test.sv
// ***
// Bench
// ***
module bit_clear_and_negative_branch_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bcbn_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic extended_en = 1'b0;
  logic negative_flag = 1'b0;
  logic [3:0] bank_selector = 4'h0;
  logic [11:0] index_base = 12'h000;
  logic [11:0] exp_fa = 12'h000;
  logic [PC_W-1:0] adr = PC_RESET;
  logic [15:0] instr;
  logic instr_valid, busy, instr_done;
  logic [PC_W-1:0] pc;
  logic [1:0] phase;
  logic [ADDR_W-1:0] file_addr;
  logic [31:0] r;
  logic [7:0] f, n;
  logic [15:0] word;
  logic [36:0] note;
  logic [36:0] notes [$];
  int mismatches = 0;
  int cmp_count = 0;
  bcbn_core dut (.clk(clk), .reset(reset), .instr(instr), .instr_valid(instr_valid), .bank_selector(bank_selector),
    .index_base(index_base), .extended_en(extended_en), .negative_flag(negative_flag), .pc(pc), .phase(phase),
    .busy(busy), .instr_done(instr_done), .branch_taken(), .illegal(), .file_addr(file_addr));
  bcbn_fetch_model fetch (.word_sel(pc[8:1]), .instr(instr), .instr_valid(instr_valid));
  initial forever #10 clk = ~clk;
  task automatic chk_pc(logic [PC_W-1:0] e, logic [PC_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR pc expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_fa(logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR file_addr expected %h seen %h", e, g);
    end
  endtask
  task automatic chk_bit(logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR cleared_bit expected %h seen %h", e, g);
    end
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Store the word, wait for its latch, then hold its operands until the next latch
  task automatic run(logic [15:0] w, logic [3:0] bs, logic [11:0] ib, logic ex, logic ng);
    fetch.rom[adr[8:1]] <= w;
    do @(posedge clk); while (phase !== PHASE_Q1 || busy !== 1'b0);
    bank_selector <= bs;
    index_base <= ib;
    extended_en <= ex;
    negative_flag <= ng;
    if (w[15:12] == BCLR_PREFIX)
      exp_fa = w[8] ? {bs, w[7:0]} : (ex && w[7:0] <= INDEXED_LIMIT) ? ib + {4'h0, w[7:0]} :
        {((w[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK), w[7:0]};
    adr = adr + PC_STEP + ((w[15:8] == BNEG_OPCODE && ng) ? {{12{w[7]}}, w[7:0], 1'b0} : PC_RESET);
    notes.push_back({w[15:12] == BCLR_PREFIX, w[11:9], adr, exp_fa});
  endtask
  // At completion the next word is not yet latched, so pc shows the next address itself
  always @(negedge clk) begin
    if (instr_done === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      chk_pc(note[32:12], pc);
      chk_fa(note[11:0], file_addr);
      if (note[36]) chk_bit(1'b0, dut.u_mem.mem_r[file_addr][note[35:33]]);
    end
  end
  initial begin
    void'($urandom(32'h6920af4b));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Addresses 5f/60 and offsets 7f/80 recur as boundary cases; every seventh word is neither kind
    for (int i = 0; i < 80; i++) begin
      r = $urandom;
      f = (i % 3 == 0) ? INDEXED_LIMIT + {7'h00, r[0]} : r[7:0];
      n = (i % 5 == 0) ? {~r[1], {7{r[1]}}} : r[9:2];
      word = (i % 7 == 3) ? {8'h00, r[7:0]} : r[31] ? {BCLR_PREFIX, r[12:10], r[13], f} : {BNEG_OPCODE, n};
      run(word, r[17:14], r[29:18], r[30], r[0] ^ r[5]);
    end
    for (int k = 0; k < 20 && notes.size() > 0; k++)
      @(posedge clk);
    if (notes.size() > 0) begin
      mismatches++;
      $display("ERROR notes expected 0 seen %0d", notes.size());
    end
    print_verdict();
  end
  // Worst case is 69 taken branches of 8 cycles each, the 11 words of neither kind taking 4
  initial begin
    repeat (1500) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
bind bcbn_core bcbn_core_properties props (.clk(clk), .reset(reset), .instr(instr), .bank_selector(bank_selector),
  .index_base(index_base), .extended_en(extended_en), .negative_flag(negative_flag), .pc(pc), .phase(phase),
  .busy(busy), .instr_done(instr_done), .branch_taken(branch_taken), .illegal(illegal), .file_addr(file_addr));
